// ### include/pts_pkg.sv
// Constants, register map and field types of the pulse trigger sequencer
`default_nettype none
package pts_pkg;
	// Clock and timing
	localparam int CLK_PS      = 5000;        // Clock period in ps
	localparam int CLK_HZ      = 200000000;   // Clock rate in Hz
	localparam int WMIN_PS     = 3020;        // Least pulse width in ps
	localparam int WMIN_CYC    = (WMIN_PS + CLK_PS - 1) / CLK_PS;
	localparam int IVL_MIN_PS  = 6060;        // Least trigger interval in ps
	localparam int IVL_MIN_CYC = (IVL_MIN_PS + CLK_PS - 1) / CLK_PS;
	localparam int RATE_MAX_HZ = 165000000;   // Highest trigger rate in Hz
	localparam int MARK_CYC    = IVL_MIN_CYC - 1; // Marker length, below least period
	localparam int DIV_STEPS   = 28;          // Quotient bits of CLK_HZ divide
	// Register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_PERIOD = 8'h04;
	localparam logic [7:0] A_WIDTH  = 8'h08;
	localparam logic [7:0] A_RATE   = 8'h0c;
	localparam logic [7:0] A_IVL    = 8'h10;
	localparam logic [7:0] A_BURST  = 8'h14;
	localparam logic [7:0] A_PAT    = 8'h18;
	localparam logic [7:0] A_PLEN   = 8'h1c;
	localparam logic [7:0] A_STRB   = 8'h20;
	localparam logic [7:0] A_CMD    = 8'h24;
	localparam logic [7:0] A_STAT   = 8'h28;
	// Field positions
	localparam int CTRL_W    = 15;  // Control word width
	localparam int CMD_MAN   = 0;   // Manual trigger request
	localparam int CMD_APPLY = 1;   // Apply pending pattern now
	localparam int ST_ERR    = 0;   // Rejected control write, sticky
	localparam int ST_RUN    = 1;   // Unit in progress
	localparam int ST_BUSY   = 2;   // Rate/interval conversion busy
	localparam int ST_IDX    = 8;   // Low bit of period index
	// Reset values
	localparam logic [31:0] PERIOD_RST = 32'h00000064;
	localparam logic [31:0] WIDTH_RST  = 32'h0000000a;
	localparam logic [31:0] IVL_RST    = 32'h000000c8;
	localparam logic [31:0] RATE_RST   = 32'h000f4240;
	localparam logic [31:0] BURST_RST  = 32'h00000004;
	localparam logic [31:0] PLEN_RST   = 32'h00000008;
	// Field encodings
	typedef enum logic [1:0] {STY_FREE, STY_TRIG, STY_GATE} pts_style_t;
	typedef enum logic [1:0] {ORG_EXT, ORG_RATE, ORG_MAN} pts_origin_t;
	typedef enum logic [1:0] {EDG_RISE, EDG_FALL, EDG_BOTH} pts_edge_t;
	typedef enum logic [1:0] {PER_OSC, PER_RATE, PER_CLK} pts_per_t;
	typedef enum logic [1:0] {OPM_PULSE, OPM_BURST, OPM_PAT, OPM_XWID} pts_mode_t;
	// Control word, most significant field first
	typedef struct packed {
		logic        enable;            // Channel enable
		pts_style_t  trigger_style;     // Free, one-shot or gated
		pts_origin_t trigger_origin_select;
		pts_edge_t   trigger_edge_select;
		pts_per_t    period_origin_select;
		logic        period_clock_edge_select; // 0 rising, 1 falling
		logic        pulses_per_period; // 0 single, 1 double
		pts_mode_t   op_mode;           // Pulse, burst, pattern, external width
		logic        update_cont;       // Pattern edits take effect at once
		logic        rz;                // Pattern return-to-zero format
	} pts_ctrl_t;
endpackage : pts_pkg
`default_nettype wire

// ### hdl/pts_top.sv
// Trigger and period sequencer of one pulse, burst and pattern channel
// How it works
// - Three trigger styles: free, one-shot, gated
// - Free style starts at channel enable
// - Each trigger seen in idle launches one pulse, burst, pattern
// - Gate leading edge starts, trailing ends
// - Trigger edge rising, falling or both
// - One trigger origin: external, rate, manual
// - Manual request gives one trigger each
// - Rate generator never both period and trigger
// - Writing rate sets interval to reciprocal
// - Writing interval sets rate to reciprocal
// - Pattern edits apply now or on request
// - Width clamped between minimum and period minus minimum; external clock periods clamp to the minimum only
// - Marker for every pulse or bit period
// - Burst strobe high first, low last
// - Pattern strobe programmed; pulse and external width strobe idle
// - One or two pulses per period
// - Period from oscillator, rate generator, clock
// - External clock edge rising or falling
// - External width follows trigger input only
// - Free output stops when channel disabled
// - Unsynced sources start after second period tick
//
// Implementation choices: register access over APB and the register offsets.
`default_nettype none
module pts_top (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Pins
	input  wire logic        external_trigger_input,
	input  wire logic        external_period_clock,
	output logic             chan_out,
	output logic             period_marker,
	output logic             strobe_out
);
	typedef enum {S_IDLE, S_ARM, S_RUN} pts_state_t;

	// Configuration registers
	pts_pkg::pts_ctrl_t ctrl_ff;      // Control word
	logic [31:0] period_ff;           // Oscillator period, cycles
	logic [31:0] width_ff;            // Pulse width, cycles
	logic [31:0] rate_ff;             // Trigger rate, Hz
	logic [31:0] ivl_ff;              // Trigger interval, cycles
	logic [31:0] burst_ff;            // Periods per burst
	logic [31:0] pat_ff;              // Pattern in use
	logic [31:0] pat_sh_ff;           // Pattern being edited
	logic [4:0]  plen_ff;             // Pattern length minus one
	logic [31:0] strb_ff;             // Strobe bit pattern
	logic        err_ff;              // Rejected control write
	logic        man_ff;              // Manual trigger pulse
	// Bus handshake
	logic        ack_ff;              // Access phase answered
	logic [31:0] prdata_ff;           // Read data
	logic        slverr_ff;           // Unmapped address
	logic        blocked;             // Conversion in flight
	logic        hit;                 // Address decodes
	logic [31:0] rd_mux;              // Read value
	logic        wr;                  // Write takes effect
	// Divider
	logic        div_busy_ff;
	logic [4:0]  div_cnt_ff;
	logic [32:0] div_rem_ff;
	logic [27:0] div_num_ff;
	logic [31:0] div_den_ff;
	logic [31:0] div_q_ff;
	logic        div_to_ivl_ff;      // Result goes to interval
	logic        div_start;
	logic [31:0] div_arg;
	logic        div_arg_ivl;
	logic [32:0] div_t;
	logic        div_bit;
	logic        div_done;
	logic [31:0] div_res;
	// Synchronisers and edges
	logic [1:0]  ext_s_ff;
	logic [1:0]  clk_s_ff;
	logic        ext_q_ff;
	logic        clk_q_ff;
	logic        ext_rise;
	logic        ext_fall;
	logic        clk_tick;
	// Period and trigger sources
	logic [31:0] rg_cnt_ff;
	logic [31:0] vco_cnt_ff;
	logic        rg_rise;
	logic        rg_fall;
	logic        src_tick;
	logic        trig_ev;
	// Sequencer
	pts_state_t  state_ff;
	logic        skip_ff;             // One source tick still to skip
	logic        live_ff;             // A unit is in progress
	logic [31:0] idx_ff;              // Period index inside unit
	logic [31:0] ph_ff;               // Cycles since period start
	logic        strb_lvl_ff;         // Burst strobe level
	logic        mark_d_ff;
	logic [31:0] len;                 // Periods in a unit
	logic        last;
	logic        again;               // Start a further unit
	logic        ptick;
	logic        pstart;
	logic        start;
	logic        vco_restart;
	logic [31:0] eff_w;
	logic [31:0] plim;
	logic        bit_now;
	logic        pulse_hi;
	logic [1:0]  mark_cnt_ff;

	// APB answer one cycle into the access phase
	assign blocked = div_busy_ff && (paddr == pts_pkg::A_RATE || paddr == pts_pkg::A_IVL);
	assign pready  = ack_ff;
	assign prdata  = prdata_ff;
	assign pslverr = slverr_ff;
	assign wr      = psel && penable && pready && pwrite && hit;

	// Read decode
	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h00000000;
		if (paddr == pts_pkg::A_CTRL) begin
			rd_mux = {{(32 - pts_pkg::CTRL_W){1'b0}}, ctrl_ff};
		end else if (paddr == pts_pkg::A_PERIOD) begin
			rd_mux = period_ff;
		end else if (paddr == pts_pkg::A_WIDTH) begin
			rd_mux = width_ff;
		end else if (paddr == pts_pkg::A_RATE) begin
			rd_mux = rate_ff;
		end else if (paddr == pts_pkg::A_IVL) begin
			rd_mux = ivl_ff;
		end else if (paddr == pts_pkg::A_BURST) begin
			rd_mux = burst_ff;
		end else if (paddr == pts_pkg::A_PAT) begin
			rd_mux = pat_sh_ff;
		end else if (paddr == pts_pkg::A_PLEN) begin
			rd_mux = {27'h0000000, plen_ff};
		end else if (paddr == pts_pkg::A_STRB) begin
			rd_mux = strb_ff;
		end else if (paddr == pts_pkg::A_CMD) begin
			rd_mux = 32'h00000000;
		end else if (paddr == pts_pkg::A_STAT) begin
			rd_mux = {16'h0000, idx_ff[7:0], 5'h00, div_busy_ff, live_ff, err_ff};
		end else begin
			hit = 1'b0;
		end
	end

	// Bus handshake flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ack_ff    <= 1'b0;
			prdata_ff <= 32'h00000000;
			slverr_ff <= 1'b0;
		end else begin
			ack_ff    <= psel && penable && !ack_ff && !blocked;
			prdata_ff <= rd_mux;
			slverr_ff <= psel && penable && !ack_ff && !blocked && !hit;
		end
	end

	// Conversion requests from rate or interval writes
	always_comb begin
		div_start = 1'b0;
		div_arg = 32'h00000001;
		div_arg_ivl = 1'b0;
		if (wr && paddr == pts_pkg::A_RATE) begin
			div_start = 1'b1;
			div_arg_ivl = 1'b1;
			if (pwdata > 32'(pts_pkg::RATE_MAX_HZ)) begin
				div_arg = 32'(pts_pkg::RATE_MAX_HZ);
			end else if (pwdata == 32'h00000000) begin
				div_arg = 32'h00000001;
			end else begin
				div_arg = pwdata;
			end
		end else if (wr && paddr == pts_pkg::A_IVL) begin
			div_start = 1'b1;
			div_arg = (pwdata < 32'(pts_pkg::IVL_MIN_CYC)) ?
				32'(pts_pkg::IVL_MIN_CYC) : pwdata;
		end
	end

	// Restoring divider: CLK_HZ over the written value
	assign div_t    = {div_rem_ff[31:0], div_num_ff[27]};
	assign div_bit  = div_t >= {1'b0, div_den_ff};
	assign div_done = div_busy_ff && div_cnt_ff == 5'(pts_pkg::DIV_STEPS - 1);
	assign div_res  = {div_q_ff[30:0], div_bit};
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_busy_ff   <= 1'b0;
			div_cnt_ff    <= 5'h00;
			div_rem_ff    <= 33'h000000000;
			div_num_ff    <= 28'h0000000;
			div_den_ff    <= 32'h00000001;
			div_q_ff      <= 32'h00000000;
			div_to_ivl_ff <= 1'b0;
		end else if (div_start) begin
			div_busy_ff   <= 1'b1;
			div_cnt_ff    <= 5'h00;
			div_rem_ff    <= 33'h000000000;
			div_num_ff    <= 28'(pts_pkg::CLK_HZ);
			div_den_ff    <= div_arg;
			div_q_ff      <= 32'h00000000;
			div_to_ivl_ff <= div_arg_ivl;
		end else if (div_busy_ff) begin
			div_rem_ff <= div_bit ? (div_t - {1'b0, div_den_ff}) : div_t;
			div_num_ff <= {div_num_ff[26:0], 1'b0};
			div_q_ff   <= div_res;
			div_cnt_ff <= div_cnt_ff + 5'h01;
			if (div_done) begin
				div_busy_ff <= 1'b0;
			end
		end
	end

	// Software registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_ff   <= pts_pkg::pts_ctrl_t'('0);
			period_ff <= pts_pkg::PERIOD_RST;
			width_ff  <= pts_pkg::WIDTH_RST;
			rate_ff   <= pts_pkg::RATE_RST;
			ivl_ff    <= pts_pkg::IVL_RST;
			burst_ff  <= pts_pkg::BURST_RST;
			pat_ff    <= 32'h00000000;
			pat_sh_ff <= 32'h00000000;
			plen_ff   <= pts_pkg::PLEN_RST[4:0];
			strb_ff   <= 32'h00000000;
			err_ff    <= 1'b0;
			man_ff    <= 1'b0;
		end else begin
			man_ff <= wr && paddr == pts_pkg::A_CMD && pwdata[pts_pkg::CMD_MAN];
			if (div_done && div_to_ivl_ff) begin
				ivl_ff <= (div_res < 32'(pts_pkg::IVL_MIN_CYC)) ?
					32'(pts_pkg::IVL_MIN_CYC) : div_res;
			end else if (div_done) begin
				rate_ff <= div_res;
			end
			if (wr && paddr == pts_pkg::A_CTRL) begin
				// Rate generator may not drive period and trigger together
				if (pwdata[13:12] != 2'(pts_pkg::STY_FREE) &&
				    pwdata[11:10] == 2'(pts_pkg::ORG_RATE) &&
				    pwdata[7:6] == 2'(pts_pkg::PER_RATE)) begin
					err_ff <= 1'b1;
				end else begin
					ctrl_ff <= pts_pkg::pts_ctrl_t'(pwdata[pts_pkg::CTRL_W-1:0]);
				end
			end else if (wr && paddr == pts_pkg::A_STAT && pwdata[pts_pkg::ST_ERR]) begin
				err_ff <= 1'b0;
			end
			if (wr && paddr == pts_pkg::A_PERIOD) begin
				period_ff <= (pwdata < 32'(pts_pkg::IVL_MIN_CYC)) ?
					32'(pts_pkg::IVL_MIN_CYC) : pwdata;
			end
			if (wr && paddr == pts_pkg::A_RATE) begin
				rate_ff <= div_arg;
			end
			if (wr && paddr == pts_pkg::A_IVL) begin
				ivl_ff <= div_arg;
			end
			if (wr && paddr == pts_pkg::A_WIDTH) begin
				width_ff <= pwdata;
			end
			if (wr && paddr == pts_pkg::A_BURST) begin
				burst_ff <= (pwdata == 32'h00000000) ? 32'h00000001 : pwdata;
			end
			if (wr && paddr == pts_pkg::A_PLEN) begin
				plen_ff <= pwdata[4:0];
			end
			if (wr && paddr == pts_pkg::A_STRB) begin
				strb_ff <= pwdata;
			end
			// Pattern edits: live in update mode, else held until applied
			if (wr && paddr == pts_pkg::A_PAT) begin
				pat_sh_ff <= pwdata;
				if (ctrl_ff.update_cont) begin
					pat_ff <= pwdata;
				end
			end else if (wr && paddr == pts_pkg::A_CMD && pwdata[pts_pkg::CMD_APPLY]) begin
				pat_ff <= pat_sh_ff;
			end
		end
	end

	// Two-flop synchronisers on the pins, then a third stage for edges
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ext_s_ff <= 2'b00;
			clk_s_ff <= 2'b00;
			ext_q_ff <= 1'b0;
			clk_q_ff <= 1'b0;
		end else begin
			ext_s_ff <= {ext_s_ff[0], external_trigger_input};
			clk_s_ff <= {clk_s_ff[0], external_period_clock};
			ext_q_ff <= ext_s_ff[1];
			clk_q_ff <= clk_s_ff[1];
		end
	end
	assign ext_rise = ext_s_ff[1] && !ext_q_ff;
	assign ext_fall = !ext_s_ff[1] && ext_q_ff;
	assign clk_tick = ctrl_ff.period_clock_edge_select ?
		(!clk_s_ff[1] && clk_q_ff) : (clk_s_ff[1] && !clk_q_ff);

	// Internal rate generator: rise at count zero, fall at half interval
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rg_cnt_ff <= 32'h00000000;
		end else if (rg_cnt_ff >= ivl_ff - 32'h00000001) begin
			rg_cnt_ff <= 32'h00000000;
		end else begin
			rg_cnt_ff <= rg_cnt_ff + 32'h00000001;
		end
	end
	assign rg_rise = rg_cnt_ff == 32'h00000000;
	assign rg_fall = rg_cnt_ff == (ivl_ff >> 1);

	// Internal oscillator, restarted so it fires right at a trigger
	always_ff @(posedge sys_clk) begin
		if (rst || vco_restart || vco_cnt_ff >= period_ff - 32'h00000001) begin
			vco_cnt_ff <= 32'h00000000;
		end else begin
			vco_cnt_ff <= vco_cnt_ff + 32'h00000001;
		end
	end

	// Period source select
	always_comb begin
		case (ctrl_ff.period_origin_select)
			pts_pkg::PER_RATE: src_tick = rg_rise;
			pts_pkg::PER_CLK:  src_tick = clk_tick;
			default:           src_tick = vco_cnt_ff == 32'h00000000;
		endcase
	end

	// Trigger origin and edge select
	always_comb begin
		case (ctrl_ff.trigger_origin_select)
			pts_pkg::ORG_RATE: begin
				case (ctrl_ff.trigger_edge_select)
					pts_pkg::EDG_FALL: trig_ev = rg_fall;
					pts_pkg::EDG_BOTH: trig_ev = rg_rise || rg_fall;
					default:           trig_ev = rg_rise;
				endcase
			end
			pts_pkg::ORG_MAN: trig_ev = man_ff;
			default: begin
				case (ctrl_ff.trigger_edge_select)
					pts_pkg::EDG_FALL: trig_ev = ext_fall;
					pts_pkg::EDG_BOTH: trig_ev = ext_rise || ext_fall;
					default:           trig_ev = ext_rise;
				endcase
			end
		endcase
	end

	// Unit length and repeat decision
	always_comb begin
		case (ctrl_ff.op_mode)
			pts_pkg::OPM_BURST: len = burst_ff;
			pts_pkg::OPM_PAT:   len = {27'h0000000, plen_ff} + 32'h00000001;
			default:            len = 32'h00000001;
		endcase
		case (ctrl_ff.trigger_style)
			pts_pkg::STY_FREE: again = 1'b1;
			pts_pkg::STY_GATE: again = ext_s_ff[1];
			default:           again = 1'b0;
		endcase
	end
	assign last   = live_ff && idx_ff == len - 32'h00000001;
	// Disable blocks the period tick at once; a marker already in the pipeline still follows
	assign ptick  = src_tick && ctrl_ff.enable &&
		(state_ff == S_RUN || (state_ff == S_ARM && !skip_ff));
	assign pstart = ptick && !(last && !again);

	// Start condition from idle; later triggers fall through unseen
	always_comb begin
		case (ctrl_ff.trigger_style)
			pts_pkg::STY_FREE: start = 1'b1;
			pts_pkg::STY_GATE: start = ext_rise;
			default:           start = trig_ev;
		endcase
		start = start && ctrl_ff.enable && state_ff == S_IDLE &&
			ctrl_ff.op_mode != pts_pkg::OPM_XWID;
	end
	assign vco_restart = start && ctrl_ff.period_origin_select == pts_pkg::PER_OSC;

	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (rst || !ctrl_ff.enable || ctrl_ff.op_mode == pts_pkg::OPM_XWID) begin
			state_ff    <= S_IDLE;
			skip_ff     <= 1'b0;
			live_ff     <= 1'b0;
			idx_ff      <= 32'h00000000;
			strb_lvl_ff <= 1'b0;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (start && vco_restart) begin
						state_ff <= S_RUN;
					end else if (start) begin
						state_ff <= S_ARM;
						skip_ff  <= 1'b1;
					end
				end
				S_ARM: begin
					if (src_tick) begin
						skip_ff <= 1'b0;
					end
				end
				default: begin
				end
			endcase
			if (ptick) begin
				if (!live_ff || last) begin
					if (!live_ff || again) begin
						state_ff    <= S_RUN;
						live_ff     <= 1'b1;
						idx_ff      <= 32'h00000000;
						strb_lvl_ff <= len != 32'h00000001;
					end else begin
						state_ff    <= S_IDLE;
						live_ff     <= 1'b0;
						strb_lvl_ff <= 1'b0;
					end
				end else begin
					idx_ff <= idx_ff + 32'h00000001;
					if (idx_ff + 32'h00000001 == len - 32'h00000001) begin
						strb_lvl_ff <= 1'b0;
					end
				end
			end
		end
	end

	// Phase counter inside the period
	always_ff @(posedge sys_clk) begin
		if (rst || pstart) begin
			ph_ff <= 32'h00000000;
		end else if (ph_ff != 32'hffffffff) begin
			ph_ff <= ph_ff + 32'h00000001;
		end
	end

	// Width limited to the known period
	always_comb begin
		plim = (ctrl_ff.period_origin_select == pts_pkg::PER_RATE) ? ivl_ff : period_ff;
		eff_w = width_ff;
		if (ctrl_ff.period_origin_select != pts_pkg::PER_CLK &&
		    eff_w > plim - 32'(pts_pkg::WMIN_CYC)) begin
			eff_w = plim - 32'(pts_pkg::WMIN_CYC);
		end
		if (eff_w < 32'(pts_pkg::WMIN_CYC)) begin
			eff_w = 32'(pts_pkg::WMIN_CYC);
		end
		// Second pulse follows after a gap equal to the width
		pulse_hi = ph_ff < eff_w ||
			(ctrl_ff.pulses_per_period && ph_ff >= (eff_w << 1) &&
			 ph_ff < eff_w * 32'h00000003);
		bit_now = pat_ff[idx_ff[4:0]];
	end

	// Marker stretch counter
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mark_cnt_ff <= 2'b00;
		end else if (mark_d_ff) begin
			mark_cnt_ff <= 2'(pts_pkg::MARK_CYC);
		end else if (mark_cnt_ff != 2'b00) begin
			mark_cnt_ff <= mark_cnt_ff - 2'b01;
		end
	end

	// Output registers, marker delayed to line up with the channel
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mark_d_ff     <= 1'b0;
			period_marker <= 1'b0;
			chan_out      <= 1'b0;
			strobe_out    <= 1'b0;
		end else if (ctrl_ff.op_mode == pts_pkg::OPM_XWID) begin
			mark_d_ff     <= ctrl_ff.enable && ext_rise;
			period_marker <= mark_d_ff;
			chan_out      <= ctrl_ff.enable && ext_q_ff;
			strobe_out    <= 1'b0;
		end else begin
			mark_d_ff     <= pstart;
			period_marker <= mark_d_ff || (mark_cnt_ff > 2'b01);
			case (ctrl_ff.op_mode)
				pts_pkg::OPM_PAT: begin
					chan_out   <= live_ff && bit_now && (!ctrl_ff.rz || ph_ff < eff_w);
					strobe_out <= live_ff && strb_ff[idx_ff[4:0]];
				end
				pts_pkg::OPM_BURST: begin
					chan_out   <= live_ff && pulse_hi;
					strobe_out <= strb_lvl_ff;
				end
				default: begin
					chan_out   <= live_ff && pulse_hi;
					strobe_out <= 1'b0;
				end
			endcase
		end
	end
endmodule : pts_top
`default_nettype wire

// ### verif/pts_top_assertions.sv
// Port checker for the pulse trigger sequencer
`default_nettype none
module pts_top_assertions (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// APB
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Pins
	input wire logic        external_trigger_input,
	input wire logic        external_period_clock,
	input wire logic        chan_out,
	input wire logic        period_marker,
	input wire logic        strobe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	pts_pkg::pts_ctrl_t ctl_ff; // Control word as it should stand
	logic               bad;    // Rate generator asked for twice
	logic               acc;    // Completed transfer to the control word
	assign bad = pwdata[13:12] != 2'h0 && pwdata[11:10] == 2'h1 && pwdata[7:6] == 2'h1;
	assign acc = psel && penable && pready && paddr == pts_pkg::A_CTRL;
	// Shadow of accepted control writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctl_ff <= '0;
		end else if (acc && pwrite && !bad) begin
			ctl_ff <= pts_pkg::pts_ctrl_t'(pwdata[14:0]);
		end
	end
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_READY_ACCESS: assert property (pready |-> psel && penable && $past(psel))
		else $error("ready outside access");
	AST_RST_QUIET: assert property ($past(rst) |-> !chan_out && !period_marker && !strobe_out)
		else $error("output busy after reset");
	AST_MARK_ONE: assert property (period_marker |=> !period_marker)
		else $error("marker longer than one cycle");
	AST_FREE_OFF: assert property ((!ctl_ff.enable && ctl_ff.op_mode != pts_pkg::OPM_XWID) [*3]
		|-> !chan_out && !period_marker)
		else $error("output while disabled");
	AST_STROBE_IDLE: assert property ((ctl_ff.op_mode == pts_pkg::OPM_PULSE) [*3] |-> !strobe_out)
		else $error("strobe in pulse mode");
	AST_MARK_CHAN: assert property (period_marker && ctl_ff.enable && ctl_ff.op_mode[1] == 1'b0
		|-> chan_out)
		else $error("marker without pulse");
	AST_CTRL_READ: assert property (acc && !pwrite |-> prdata[14:0] == ctl_ff)
		else $error("control readback wrong");
	cover property (period_marker);
	cover property ($rose(strobe_out));
	cover property (pslverr);
endmodule : pts_top_assertions
bind pts_top pts_top_assertions chk_u (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .external_trigger_input(external_trigger_input),
	.external_period_clock(external_period_clock), .chan_out(chan_out),
	.period_marker(period_marker), .strobe_out(strobe_out));
`default_nettype wire

// ### verif/pts_far_model.sv
// Trigger source and downstream instrument at the channel pins
`default_nettype none
module pts_far_model (
	// Clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst,
	// Bench command
	input  wire logic   trig_level,
	// Block pins
	input  wire logic   period_marker,
	input  wire logic   strobe_out,
	output logic        external_trigger_input,
	output logic        external_period_clock,
	// Seen by the instrument
	output logic [15:0] mark_cnt,
	output logic [15:0] strb_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic strb_d; // Strobe last cycle
	assign external_trigger_input = trig_level;
	assign external_period_clock  = 1'b0; // Clock rests, no frames sent
	// Count markers and strobe rises
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mark_cnt <= '0;
			strb_cnt <= '0;
		end else begin
			mark_cnt <= mark_cnt + 16'(period_marker);
			strb_cnt <= strb_cnt + 16'(strobe_out && !strb_d);
		end
		strb_d <= strobe_out;
	end
endmodule : pts_far_model
`default_nettype wire

// ### verif/pulse_trigger_sequencer_tb.sv
// Self-checking bench for the pulse trigger sequencer
`default_nettype none
module pulse_trigger_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d, m; logic e;} pts_row_t;
	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, trig, er;
	logic        ext_trig, ext_clk, chan_out, period_marker, strobe_out;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] mark_cnt, strb_cnt, m0, s0;
	int          fails = 0;
	int          checked = 0;
	pts_row_t    rows[17] = '{'{0, 8'h04, pts_pkg::PERIOD_RST, '1, 0},
		'{0, 8'h08, pts_pkg::WIDTH_RST, '1, 0}, '{0, 8'h0c, pts_pkg::RATE_RST, '1, 0},
		'{0, 8'h10, pts_pkg::IVL_RST, '1, 0}, '{0, 8'h14, pts_pkg::BURST_RST, '1, 0},
		'{0, 8'h1c, pts_pkg::PLEN_RST, '1, 0}, '{0, 8'h00, 32'h0, 32'h7fff, 0},
		'{0, 8'h40, 32'h0, 32'h0, 1}, '{1, 8'h0c, 32'h001e8480, '1, 0},
		'{0, 8'h10, 32'h00000064, '1, 0}, '{1, 8'h10, 32'h00000190, '1, 0},
		'{0, 8'h0c, 32'h0007a120, '1, 0}, '{1, 8'h00, 32'h00001440, '1, 0},
		'{0, 8'h00, 32'h0, 32'h7fff, 0}, '{0, 8'h28, 32'h1, 32'h1, 0},
		'{1, 8'h28, 32'h1, '1, 0}, '{0, 8'h28, 32'h0, 32'h1, 0}};
	pts_top dut_u (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .external_trigger_input(ext_trig),
		.external_period_clock(ext_clk), .chan_out(chan_out),
		.period_marker(period_marker), .strobe_out(strobe_out));
	pts_far_model far_u (.sys_clk(sys_clk), .rst(rst), .trig_level(trig),
		.period_marker(period_marker), .strobe_out(strobe_out),
		.external_trigger_input(ext_trig), .external_period_clock(ext_clk),
		.mark_cnt(mark_cnt), .strb_cnt(strb_cnt));
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask : chk
	// One APB transfer, waits for ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 100) chk(32'h0, 32'h1, "no ready");
	endtask : apb
	task automatic wcyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wcyc
	// Print counts and verdict
	task automatic results();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Watchdog
	initial begin
		#50000;
		fails++;
		$display("MISMATCH at %0t: watchdog", $time);
		results();
	end
	// Main sequence
	initial begin
		{rst, psel, penable, pwrite, trig, paddr, pwdata} = {5'h10, 8'h00, 32'h0};
		wcyc(4);
		rst <= 1'b0;
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk(rd & rows[i].m, rows[i].d & rows[i].m, "read");
			chk(32'(er), 32'(rows[i].e), "error flag");
		end
		$display("test registers done");
		apb(1'b1, pts_pkg::A_WIDTH, 32'h3);
		apb(1'b1, pts_pkg::A_PERIOD, 32'ha);
		apb(1'b1, pts_pkg::A_CTRL, 32'h4000);
		m0 = mark_cnt;
		wcyc(100);
		chk(32'(mark_cnt - m0 inside {[16'd9 : 16'd11]}), 32'h1, "free markers");
		apb(1'b1, pts_pkg::A_CTRL, 32'h0);
		wcyc(5);
		m0 = mark_cnt;
		wcyc(50);
		chk(32'(mark_cnt - m0), 32'h0, "stop on disable");
		$display("test free done");
		apb(1'b1, pts_pkg::A_CTRL, 32'h5804);
		{m0, s0} = {mark_cnt, strb_cnt};
		apb(1'b1, pts_pkg::A_CMD, 32'h1);
		apb(1'b1, pts_pkg::A_CMD, 32'h1);
		wcyc(100);
		chk(32'(mark_cnt - m0), pts_pkg::BURST_RST, "burst markers");
		chk(32'(strb_cnt - s0), 32'h1, "burst strobe");
		$display("test manual burst done");
		apb(1'b1, pts_pkg::A_STRB, 32'h5);
		apb(1'b1, pts_pkg::A_CTRL, 32'h580a);
		{m0, s0} = {mark_cnt, strb_cnt};
		apb(1'b1, pts_pkg::A_CMD, 32'h1);
		wcyc(120);
		chk(32'(mark_cnt - m0), pts_pkg::PLEN_RST + 1, "pattern markers");
		chk(32'(strb_cnt - s0), 32'h2, "pattern strobe");
		$display("test pattern done");
		for (int e = 0; e < 4; e++) begin
			// Last pass is gated: 40 cycles open over a 10 cycle period
			apb(1'b1, pts_pkg::A_CTRL, (e == 3) ? 32'h6000 : 32'h5000 | 32'(e << 8));
			m0 = mark_cnt;
			trig <= 1'b1;
			wcyc(40);
			trig <= 1'b0;
			wcyc(40);
			chk(32'(mark_cnt - m0), (e == 3) ? 32'h4 : (e == 2) ? 32'h2 : 32'h1,
				"edge markers");
		end
		$display("test trigger edges done");
		rst <= 1'b1;
		wcyc(2);
		rst <= 1'b0;
		apb(1'b0, pts_pkg::A_CTRL, 32'h0);
		chk(rd, 32'h0, "control after reset");
		$display("test reset done");
		results();
	end
endmodule : pulse_trigger_sequencer_tb
`default_nettype wire
